// [sfim_core.sv]
// Interrupt mask registers, event flags and combined interrupt request.
// Assumes the serial bus decoder delivers one-cycle read and write strobes on clk_sys,
// and that event sources are synchronous logic on clk_sys.
//
// Behaviour
// [RULE1] Mask A bit 22 set blocks the pre-regulator overcurrent interrupt; resets zero.
// [RULE2] Mask A bit 20 set blocks the core buck overcurrent interrupt; resets zero.
// [RULE3] Mask A bit 18 set blocks the second buck overcurrent interrupt; resets zero.
// [RULE4] Mask A bit 17 set blocks the linear regulator overcurrent interrupt; resets zero.
// [RULE5] Mask A bit 12 set blocks the core buck overtemperature interrupt; resets zero.
// [RULE6] Mask A bit 10 set blocks the second buck overtemperature interrupt; resets zero.
// [RULE7] Mask A bit 9 set blocks the linear regulator overtemperature interrupt; resets zero.
// [RULE8] Mask B bit 18 set blocks the bias supply high undervoltage interrupt; resets zero.
// [RULE9] Mask B bit 17 set blocks the communication error interrupt; resets zero.
// [RULE10] Mask B bit 16 set blocks the pre-regulator feedback overvoltage interrupt; resets zero.
// [RULE11] Mask B bit 14 set blocks the supply undervoltage-seven interrupt; resets zero.
// [RULE12] Mask B bit 12 set blocks its high-threshold undervoltage interrupt; resets zero.
// [RULE13] Mask B bit 11 set blocks the supply low undervoltage interrupt; resets zero.
// [RULE14] Mask B bit 10 set blocks its high-threshold undervoltage interrupt; resets zero.
// [RULE15] Mask B bit 9 set blocks the first wake input interrupt; resets zero.
// [RULE16] Mask B bit 8 set blocks the second wake input interrupt; resets zero.
// [RULE17] Flags set on events, clear on write one, and clear at reset.
// [RULE18] Request is high while any flag is set with mask clear; reserved bits read zero.
module sfim_core
(
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    input  wire logic [sfim_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sfim_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [sfim_pkg::DATA_W-1:0] event_a,
    input  wire logic [sfim_pkg::DATA_W-1:0] event_b,
    output logic      [sfim_pkg::DATA_W-1:0] reg_rdata,
    output logic                             reg_rvalid,
    output logic                             int_request
);
    import sfim_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [DATA_W-1:0] mask_a;
    logic [DATA_W-1:0] mask_b;
    logic [DATA_W-1:0] flag_a;
    logic [DATA_W-1:0] flag_b;
    logic [DATA_W-1:0] next_mask_a;
    logic [DATA_W-1:0] next_mask_b;
    logic [DATA_W-1:0] next_flag_a;
    logic [DATA_W-1:0] next_flag_b;
    logic [DATA_W-1:0] next_reg_rdata;
    logic              next_reg_rvalid;
    logic              next_int_request;
    logic [DATA_W-1:0] pend_a;
    logic [DATA_W-1:0] pend_b;
    logic [3:0]        sel_write;
    logic [3:0]        sel_read;

    // Maps a frame bit number to its position in the 16-bit register.
    function automatic logic [3:0] pos(input int unsigned frame_bit);
        pos = 4'(frame_bit - FRAME_LSB);
    endfunction : pos

    // Pending term of one source: flag raised and mask clear.
    function automatic logic pend(input logic [DATA_W-1:0] flags,
                                  input logic [DATA_W-1:0] masks,
                                  input int unsigned       frame_bit);
        pend = flags[pos(frame_bit)] & ~masks[pos(frame_bit)];
    endfunction : pend

    // One decoder serves the write and the read path, so the two can never disagree on the map.
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
        decode = 4'h0;
        case (addr)
            ADDR_MASK_A: decode = 4'h1;
            ADDR_MASK_B: decode = 4'h2;
            ADDR_FLAG_A: decode = 4'h4;
            ADDR_FLAG_B: decode = 4'h8;
            default:     decode = 4'h0;
        endcase
    endfunction : decode

    assign sel_write = reg_write ? decode(reg_addr) : 4'h0;
    assign sel_read  = reg_read ? decode(reg_addr) : 4'h0;

    // ************************************************************
    // Mask registers
    // ************************************************************
    // Only implemented positions are stored, so reserved bits can never hold a stray one.
    always_comb
    begin
        next_mask_a = mask_a;
        next_mask_b = mask_b;
        if (sel_write[0])
        begin
            next_mask_a = reg_wdata & VALID_A; // RULE18
        end
        if (sel_write[1])
        begin
            next_mask_b = reg_wdata & VALID_B; // RULE18
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask_a <= MASK_A_RESET;
            mask_b <= MASK_B_RESET;
        end
        else
        begin
            mask_a <= next_mask_a;
            mask_b <= next_mask_b;
        end
    end

    // ************************************************************
    // Event flags
    // ************************************************************
    // Flags sit at the same positions as their mask bits. This is a local layout, so software
    // written for another flag map must not assume it.
    always_comb
    begin
        next_flag_a = flag_a;
        next_flag_b = flag_b;
        if (sel_write[2])
        begin
            next_flag_a = flag_a & ~reg_wdata; // RULE17
        end
        if (sel_write[3])
        begin
            next_flag_b = flag_b & ~reg_wdata; // RULE17
        end
        // The event is merged after the clear, so an event in the clear cycle keeps its flag.
        next_flag_a = (next_flag_a | event_a) & VALID_A; // RULE17
        next_flag_b = (next_flag_b | event_b) & VALID_B; // RULE17
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_a <= FLAG_RESET; // RULE17
            flag_b <= FLAG_RESET; // RULE17
        end
        else
        begin
            flag_a <= next_flag_a;
            flag_b <= next_flag_b;
        end
    end

    // ************************************************************
    // Interrupt gating
    // ************************************************************
    // Each source is listed so that a masked bit can be traced to its own term.
    always_comb
    begin
        pend_a = '0;
        pend_b = '0;
        pend_a[pos(A_PREREG_OC)]      = pend(flag_a, mask_a, A_PREREG_OC);      // RULE1
        pend_a[pos(A_CORE_BUCK_OC)]   = pend(flag_a, mask_a, A_CORE_BUCK_OC);   // RULE2
        pend_a[pos(A_SECOND_BUCK_OC)] = pend(flag_a, mask_a, A_SECOND_BUCK_OC); // RULE3
        pend_a[pos(A_LINEAR_REG_OC)]  = pend(flag_a, mask_a, A_LINEAR_REG_OC);  // RULE4
        pend_a[pos(A_CORE_BUCK_OT)]   = pend(flag_a, mask_a, A_CORE_BUCK_OT);   // RULE5
        pend_a[pos(A_SECOND_BUCK_OT)] = pend(flag_a, mask_a, A_SECOND_BUCK_OT); // RULE6
        pend_a[pos(A_LINEAR_REG_OT)]  = pend(flag_a, mask_a, A_LINEAR_REG_OT);  // RULE7
        pend_b[pos(B_BIAS_UV_HIGH)]   = pend(flag_b, mask_b, B_BIAS_UV_HIGH);   // RULE8
        pend_b[pos(B_COMM_ERROR)]     = pend(flag_b, mask_b, B_COMM_ERROR);     // RULE9
        pend_b[pos(B_PREREG_FB_OV)]   = pend(flag_b, mask_b, B_PREREG_FB_OV);   // RULE10
        pend_b[pos(B_SUPPLY_UV7)]     = pend(flag_b, mask_b, B_SUPPLY_UV7);     // RULE11
        pend_b[pos(B_PREREG_UV_HIGH)] = pend(flag_b, mask_b, B_PREREG_UV_HIGH); // RULE12
        pend_b[pos(B_SUPPLY_UV_LOW)]  = pend(flag_b, mask_b, B_SUPPLY_UV_LOW);  // RULE13
        pend_b[pos(B_SUPPLY_UV_HIGH)] = pend(flag_b, mask_b, B_SUPPLY_UV_HIGH); // RULE14
        pend_b[pos(B_FIRST_WAKE)]     = pend(flag_b, mask_b, B_FIRST_WAKE);     // RULE15
        pend_b[pos(B_SECOND_WAKE)]    = pend(flag_b, mask_b, B_SECOND_WAKE);    // RULE16
        next_int_request = |{pend_a, pend_b}; // RULE18
    end

    // Registered so the request line never glitches while a flag and its mask change together.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            int_request <= 1'b0;
        end
        else
        begin
            int_request <= next_int_request;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Unmapped addresses read zero so software never sees stale data.
    always_comb
    begin
        next_reg_rvalid = reg_read;
        case (sel_read)
            4'h1:    next_reg_rdata = mask_a & VALID_A; // RULE18
            4'h2:    next_reg_rdata = mask_b & VALID_B; // RULE18
            4'h4:    next_reg_rdata = flag_a;
            4'h8:    next_reg_rdata = flag_b;
            default: next_reg_rdata = '0; // RULE18
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

endmodule : sfim_core

// [sfim_core_assertions.sv]
// Checker for the ports of the supply fault interrupt mask block.
// Assumes one clock domain and the strobe bus of the core.
module sfim_checker
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] event_a,
    input wire logic [15:0] event_b,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        int_request
);
    import sfim_pkg::*;
    // Shadow copies of the masks, so the checker knows which events may pass.
    logic [15:0] sh_a;
    logic [15:0] sh_b;
    wire cause = reg_write || |(event_a & VALID_A) || |(event_b & VALID_B);
    wire hit = |(event_a & VALID_A & ~sh_a) || |(event_b & VALID_B & ~sh_b);
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sh_a <= 16'h0000;
            sh_b <= 16'h0000;
        end
        else if (reg_write)
        begin
            if (reg_addr == ADDR_MASK_A)
                sh_a <= reg_wdata & VALID_A;
            if (reg_addr == ADDR_MASK_B)
                sh_b <= reg_wdata & VALID_B;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence int_up;
        ##2 int_request;
    endsequence
    read_answered_a: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
    idle_bus_a: assert property (!reg_read |=> !reg_rvalid && reg_rdata == 16'h0000)
        else $error("data without read");
    unmapped_zero_a: assert property (reg_read && (reg_addr < ADDR_MASK_A || reg_addr > ADDR_FLAG_B)
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    mask_a_back_a: assert property (reg_read && !reg_write && reg_addr == ADDR_MASK_A
        |=> reg_rdata == sh_a) else $error("mask a readback wrong");
    mask_b_back_a: assert property (reg_read && !reg_write && reg_addr == ADDR_MASK_B
        |=> reg_rdata == sh_b) else $error("mask b readback wrong");
    int_raise_a: assert property (!reg_write && hit |-> int_up) else $error("unmasked event lost");
    int_cause_a: assert property ($rose(int_request) |-> $past(cause, 2)) else $error("request without cause");
    reset_quiet_a: assert property ($rose(reset_n) |-> !int_request && !reg_rvalid) else $error("not quiet");
endmodule : sfim_checker
bind sfim_core sfim_checker i_chk (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .event_a(event_a), .event_b(event_b),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .int_request(int_request));

// [sfim_core_tb.sv]
// Testbench for the supply fault interrupt mask block.
// Assumes the host model drives all register traffic.
module sfim_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sfim_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic rw, rr, rv, irq;
    logic [4:0] ra, m;
    logic [15:0] wd, rd, got, bv;
    logic [15:0] ea = 16'h0000;
    logic [15:0] eb = 16'h0000;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    sfim_core i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(rw), .reg_read(rr), .reg_addr(ra),
        .reg_wdata(wd), .event_a(ea), .event_b(eb), .reg_rdata(rd), .reg_rvalid(rv), .int_request(irq));
    sfim_host i_host (.clk_sys(clk_sys), .reg_rvalid(rv), .reg_rdata(rd), .reg_write(rw), .reg_read(rr),
        .reg_addr(ra), .reg_wdata(wd));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            i_host.read(ADDR_MASK_A + 5'(k), got);
            check("mask reset", got, 16'h0000);
            i_host.write(ADDR_MASK_A + 5'(k), 16'hffff);
            i_host.read(ADDR_MASK_A + 5'(k), got);
            check("mask reserved", got, k ? VALID_B : VALID_A);
        end
        i_host.read(5'h1f, got);
        check("unmapped", got, 16'h0000);
        // Each source: masked it stays silent, unmasked it raises, cleared it drops.
        for (int j = 0; j < 32; j++)
        begin
            m = ADDR_MASK_A + 5'(j / 16);
            bv = 16'h0001 << (j % 16);
            if ((bv & (j < 16 ? VALID_A : VALID_B)) != 16'h0000)
            begin
                @(negedge clk_sys);
                ea = j < 16 ? bv : 16'h0000;
                eb = j < 16 ? 16'h0000 : bv;
                @(negedge clk_sys);
                ea = 16'h0000;
                eb = 16'h0000;
                repeat (2) @(negedge clk_sys);
                check("masked", {15'h0000, irq}, 16'h0000);
                i_host.read(m + 5'h02, got);
                check("flag", got, bv);
                i_host.write(m, ~bv);
                @(negedge clk_sys);
                check("open", {15'h0000, irq}, 16'h0001);
                i_host.write(m + 5'h02, bv);
                @(negedge clk_sys);
                check("cleared", {15'h0000, irq}, 16'h0000);
                i_host.write(m, 16'hffff);
            end
        end
        // Events on unimplemented positions must not set a flag.
        @(negedge clk_sys);
        ea = ~VALID_A;
        eb = ~VALID_B;
        @(negedge clk_sys);
        ea = 16'h0000;
        eb = 16'h0000;
        i_host.read(ADDR_FLAG_A, got);
        check("flag a reserved", got, 16'h0000);
        i_host.read(ADDR_FLAG_B, got);
        check("flag b reserved", got, 16'h0000);
        i_host.write(5'h1f, 16'h0000);
        i_host.read(ADDR_MASK_A, got);
        check("unmapped write", got, VALID_A);
        i_host.write(ADDR_MASK_B, 16'h0000);
        @(negedge clk_sys);
        eb = 16'h0001;
        @(negedge clk_sys);
        eb = 16'h0000;
        repeat (2) @(negedge clk_sys);
        check("unmasked", {15'h0000, irq}, 16'h0001);
        // A new event in the very cycle of its clear must keep the flag set.
        fork
            i_host.write(ADDR_FLAG_B, 16'h0001);
            begin
                @(negedge clk_sys);
                eb = 16'h0001;
                @(negedge clk_sys);
                eb = 16'h0000;
            end
        join
        i_host.read(ADDR_FLAG_B, got);
        check("set wins", got, 16'h0001);
        check("held irq", {15'h0000, irq}, 16'h0001);
        reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        check("reset irq", {15'h0000, irq}, 16'h0000);
        i_host.read(ADDR_MASK_A, got);
        check("mask a reset", got, 16'h0000);
        i_host.read(ADDR_FLAG_B, got);
        check("flag reset", got, 16'h0000);
        tally_and_finish();
    end
endmodule : sfim_core_tb

// [sfim_host.sv]
// Host model that drives the register strobes of the mask block.
// Assumes requests launch on the falling edge of clk_sys.
module sfim_host
(
    input  wire logic        clk_sys,
    input  wire logic        reg_rvalid,
    input  wire logic [15:0] reg_rdata,
    output logic             reg_write = 1'b0,
    output logic             reg_read = 1'b0,
    output logic [4:0]       reg_addr = 5'h00,
    output logic [15:0]      reg_wdata = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Writes invert address and data when released, reads only the address, so stale values never look valid.
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk_sys);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask : read
endmodule : sfim_host

// [sfim_pkg.sv]
// Constants shared by the supply fault interrupt mask block.
// Assumes a 24-bit register frame in which only bits 23 to 8 are implemented.
package sfim_pkg;

    // ************************************************************
    // Register frame
    // ************************************************************
    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned FRAME_LSB = 8;

    localparam logic [4:0] ADDR_MASK_A = 5'h08;
    localparam logic [4:0] ADDR_MASK_B = 5'h09;
    localparam logic [4:0] ADDR_FLAG_A = 5'h0a;
    localparam logic [4:0] ADDR_FLAG_B = 5'h0b;

    localparam logic [15:0] MASK_A_RESET = 16'h0000;
    localparam logic [15:0] MASK_B_RESET = 16'h0000;
    localparam logic [15:0] FLAG_RESET   = 16'h0000;

    // ************************************************************
    // Field positions, as frame bit numbers
    // ************************************************************
    localparam int unsigned A_PREREG_OC      = 22;
    localparam int unsigned A_CORE_BUCK_OC   = 20;
    localparam int unsigned A_SECOND_BUCK_OC = 18;
    localparam int unsigned A_LINEAR_REG_OC  = 17;
    localparam int unsigned A_CORE_BUCK_OT   = 12;
    localparam int unsigned A_SECOND_BUCK_OT = 10;
    localparam int unsigned A_LINEAR_REG_OT  = 9;

    localparam int unsigned B_BIAS_UV_HIGH   = 18;
    localparam int unsigned B_COMM_ERROR     = 17;
    localparam int unsigned B_PREREG_FB_OV   = 16;
    localparam int unsigned B_SUPPLY_UV7     = 14;
    localparam int unsigned B_PREREG_UV_HIGH = 12;
    localparam int unsigned B_SUPPLY_UV_LOW  = 11;
    localparam int unsigned B_SUPPLY_UV_HIGH = 10;
    localparam int unsigned B_FIRST_WAKE     = 9;
    localparam int unsigned B_SECOND_WAKE    = 8;

    // Implemented bits of each register, aligned to frame bit 8.
    localparam logic [15:0] VALID_A = 16'h5616;
    localparam logic [15:0] VALID_B = 16'h075f;

endpackage : sfim_pkg
